// ---- dv/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock.
  input  wire logic   CLK_I,
  // Register port and signal pin.
  output logic [7:0]  addr_o,
  output logic [31:0] wdata_o,
  output logic        wr_o,
  output logic        rd_o,
  output logic        event_o
);
  // The bus starts idle.
  initial begin
    {addr_o, wdata_o, wr_o, rd_o, event_o} = '0;
  end
  // A steady square wave stands in for the measured signal.
  always @(posedge CLK_I) event_o <= ~event_o;
  // One strobe cycle; the bus then shows inverted values, not the last ones.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_I);
    wr_o <= w;
    rd_o <= ~w;
    addr_o <= a;
    wdata_o <= d;
    @(posedge CLK_I);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "gate_arm_params.svh"
module tb;
  logic        clk, rst, opt, gate, pre, done, rd_q, seen, pre_seen, ext;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, g;
  logic        wr, rd, ev;
  logic [31:0] q[$];
  int          fail_count, checks, cyc, i;
  int          seed = 2520;
  host_model i_host (.CLK_I(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
    .rd_o(rd), .event_o(ev));
  freq_gate_arming #(.UNIT_CYCS(4)) i_freq_gate_arming (.CLK_I(clk), .RESET_I(rst),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .EXT_ARM_I(ext), .EVENT_I(ev), .OPTION_5G_I(opt), .GATE_O(gate),
    .PREMEAS_O(pre), .DONE_O(done));
  // Free-running clock.
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wrt(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d);
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    i_host.xfer(1'b0, a, '0);
  endtask
  // Start a measurement, wait for its end and note gate and pre-measurement activity.
  task automatic run(input logic [31:0] e);
    seen = 0;
    pre_seen = 0;
    wrt(`OFF_CONTROL, 32'h1);
    for (i = 0; i < 2000 && done !== 1'b1; i++) begin
      @(posedge clk);
      if (gate === 1'b1) seen = 1;
      if (pre === 1'b1) pre_seen = 1;
    end
    chk({29'h0, done, seen, pre_seen}, e);
  endtask
  // Read data stand only in the cycle after the strobe; compare there.
  always @(posedge clk) begin
    if (rd_q && q.size() > 0) chk(rdata, q.pop_front());
    rd_q <= rd;
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      final_report();
    end
  end
  // Main sequence.
  initial begin
    rst = 1;
    opt = 0;
    ext = 0;
    rd_q = 0;
    seen = 0;
    pre_seen = 0;
    repeat (8) @(posedge clk);
    rst <= 0;
    rdx(`OFF_ARM, 32'h40a);
    rdx(`OFF_GATE_TIME, 32'h2710);
    rdx(`OFF_AUTO_EST, 32'h7);
    rdx(`OFF_CH3_LEVEL, `CH3_LEVEL_VAL);
    wrt(`OFF_CH3_SLOPE, 32'h0);
    rdx(`OFF_CH3_SLOPE, `CH3_SLOPE_POS);
    rdx(8'h40, 32'h0);
    wrt(`OFF_ARM, 32'h404);
    rdx(`OFF_ARM, 32'h40a);
    rdx(`OFF_ERROR, `ERR_SETTINGS);
    wrt(`OFF_ARM, 32'h40d);
    rdx(`OFF_ARM, 32'h40a);
    wrt(`OFF_ARM, 32'h20e);
    rdx(`OFF_ARM, 32'h40a);
    rdx(`OFF_EXP1, `NAN_CODE);
    rdx(`OFF_ERROR, `ERR_SETTINGS);
    g = 32'h64 + ($unsigned($random(seed)) % 9900);
    wrt(`OFF_GATE_TIME, g);
    rdx(`OFF_GATE_TIME, g);
    wrt(`OFF_GATE_TIME, 32'h2711);
    rdx(`OFF_GATE_TIME, g);
    wrt(`OFF_EXP3, 32'h3d0900);
    rdx(`OFF_AUTO_EST, 32'h7);
    opt <= 1;
    wrt(`OFF_EXP3, 32'h3d0900);
    rdx(`OFF_AUTO_EST, 32'h3);
    wrt(`OFF_EXP1, 32'h3e8);
    wrt(`OFF_ARM, 32'h30e);
    run(32'h6);
    rdx(`OFF_COUNT_LO, 32'h64);
    // External start on a rising edge, external stop on a falling edge.
    wrt(`OFF_ARM, 32'h407);
    wrt(`OFF_CONTROL, 32'h1);
    repeat (20) @(posedge clk);
    chk({31'h0, gate}, 32'h0);
    ext <= 1;
    repeat (10) @(posedge clk);
    chk({31'h0, gate}, 32'h1);
    ext <= 0;
    repeat (5) @(posedge clk);
    chk({31'h0, gate}, 32'h0);
    // Save, reset, then a timed gate preceded by the pre-measurement step.
    wrt(`OFF_CONTROL, 32'h4);
    wrt(`OFF_CONTROL, 32'h2);
    wrt(`OFF_GATE_TIME, 32'h64);
    run(32'h7);
    // Recall restores the arm settings but leaves the frequency hints alone.
    wrt(`OFF_EXP1, 32'h3e8);
    wrt(`OFF_CONTROL, 32'h8);
    rdx(`OFF_ARM, 32'h407);
    rdx(`OFF_AUTO_EST, 32'h6);
    rdx(`OFF_EXP1, 32'h3e8);
    wrt(`OFF_AUTO_EST, 32'h5);
    rdx(`OFF_EXP1, `NAN_CODE);
    wrt(`OFF_FUNC, 32'h2);
    rdx(`OFF_FUNC, 32'h92);
    wrt(`OFF_FUNC, 32'he2);
    rdx(`OFF_FUNC, 32'h92);
    rdx(`OFF_ERROR, `ERR_RANGE);
    repeat (3) @(posedge clk);
    final_report();
  end
endmodule
`default_nettype wire

// ---- rtl/edge_pick.sv ----
`timescale 1ns/1ps
`default_nettype none
module edge_pick (
  // Clock and reset.
  input  wire logic CLK_I,
  input  wire logic RESET_I,
  // Level in, chosen polarity, edge pulse out.
  input  wire logic sig_i,
  input  wire logic rising_i,
  output logic      pulse_o
);

  logic prev;

  // Remember the previous level.
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      prev <= sig_i; // Follow the pin so release shows no false edge.
    end else begin
      prev <= sig_i;
    end
  end

  // Pulse on the selected edge only.
  assign pulse_o = rising_i ? (sig_i & ~prev) : (~sig_i & prev);

endmodule
`default_nettype wire

// ---- rtl/freq_gate_arming.sv ----
// Notes on behaviour
// - Channel three trigger level always reads back as zero volts.
// - Channel three event edge always reads back positive and cannot be set.
// - Only six start/stop pairings are accepted; others are refused whole.
// - External start edge polarity is selectable, positive after reset.
// - Start source is immediate or external, immediate after reset.
// - Digits 3 to 15, default 4, used only with a digits stop.
// - External stop edge polarity is selectable, negative after reset.
// - Stop source immediate, external, timer or digits; timer after reset; short code.
// - Gate time short 1 to 99.99 ms by 10 us, long to 1000 s by 1 ms.
// - Gate time resets to 100 ms and is used only with a timer stop.
// - Expected frequency ranges per channel, channel three set by fitted option.
// - Only an expected frequency disables the pre-measurement step for five functions.
// - Reading expected frequency while auto is on returns NaN and error -221.
// - Auto estimation accepts only on, resets on, reads back as a 3-bit mask, one bit per channel.
// - Turning auto estimation on discards any stored expected frequency.
// - Save and recall leave expected frequency and auto estimation untouched.
// - One function with its channels; ratio allows only 1,2 1,3 2,1 3,1.
`timescale 1ns/1ps
`default_nettype none
`include "gate_arm_params.svh"
module freq_gate_arming #(
  parameter int CW        = 50,
  parameter int UNIT_CYCS = `GATE_UNIT_CYC
) (
  // Clock and reset.
  input  wire logic        CLK_I,
  input  wire logic        RESET_I,
  // Register port.
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [31:0] RDATA_O,
  // Measurement pins.
  input  wire logic        EXT_ARM_I,
  input  wire logic        EVENT_I,
  input  wire logic        OPTION_5G_I,
  // Status pins.
  output logic             GATE_O,
  output logic             PREMEAS_O,
  output logic             DONE_O
);
  import gate_pkg::*;

  logic          start_ext;
  logic          start_pol;
  stop_src_t     stop_src;
  logic          stop_pol;
  logic [3:0]    digits;
  logic [26:0]   gate_units;
  logic [31:0]   exp_freq [3];
  logic [2:0]    auto_est;
  func_t         func;
  logic [1:0]    ch_a;
  logic [1:0]    ch_b;
  logic          err_flag;
  logic [31:0]   err_code;
  logic [31:0]   saved_arm;
  logic [26:0]   saved_gate;
  logic [7:0]    saved_func;
  logic          arm_pulse;
  logic [CW-1:0] count;
  logic          premeas_en;
  logic [31:0]   next_rdata;
  logic          wr_arm_ok;
  logic          wr_gate_ok;
  logic          wr_func_ok;
  logic [1:0]    new_a;
  logic [1:0]    new_b;
  logic          ctl_rst;
  logic          exp_nan_rd;
  logic          bad_wr;

  // Accepted start/stop pairings.
  function automatic logic pair_ok(input logic ext, input logic [1:0] stop);
    if (!ext) begin
      return stop != STOP_EXT;
    end
    return stop != STOP_DIG;
  endfunction

  // Gate time in 10 us units: fine short range, or whole ms long range.
  function automatic logic gate_ok(input logic [26:0] v);
    return (v >= `GATE_SHORT_MIN && v <= `GATE_SHORT_MAX) ||
           (v >= `GATE_LONG_MIN && v <= `GATE_LONG_MAX && (v % `GATE_LONG_STEP) == 27'h0);
  endfunction

  // Expected frequency range for a channel index 0..2.
  function automatic logic exp_ok(input int ch, input logic [31:0] v, input logic opt);
    if (ch < 2) begin
      return v >= `EXP12_MIN && v <= `EXP12_MAX;
    end
    if (opt) begin
      return v >= `EXP3B_MIN && v <= `EXP3B_MAX;
    end
    return v >= `EXP3A_MIN && v <= `EXP3A_MAX;
  endfunction

  // Function with its channels; zero channel fields pick the defaults.
  function automatic logic func_ok(input logic [3:0] f, input logic [1:0] a,
                                   input logic [1:0] b);
    case (f)
      FN_FREQ, FN_PERIOD:      return a != 2'h0 && b == 2'h0;
      FN_RATIO:                return (a == 2'h1 && b != 2'h1 && b != 2'h0) ||
                                      (a != 2'h1 && a != 2'h0 && b == 2'h1);
      FN_PHASE, FN_INTVL:      return a == 2'h1 && b == 2'h2;
      FN_VMAX, FN_VMIN, FN_PTP: return (a == 2'h1 || a == 2'h2) && b == 2'h0;
      FN_DUTY, FN_PWID, FN_NWID, FN_RISE, FN_FALL, FN_TOTAL:
                               return a == 2'h1 && b == 2'h0;
      default:                 return 1'b0;
    endcase
  endfunction

  // True when a function uses two channels by default.
  function automatic logic two_ch(input logic [3:0] f);
    return f == FN_RATIO || f == FN_PHASE || f == FN_INTVL;
  endfunction

  // Write decoding and validation.
  always_comb begin
    new_a      = (WDATA_I[5:4] == 2'h0) ? 2'h1 : WDATA_I[5:4];
    new_b      = (WDATA_I[7:6] == 2'h0 && two_ch(WDATA_I[3:0])) ? 2'h2 : WDATA_I[7:6];
    wr_arm_ok  = pair_ok(WDATA_I[`ARM_START_SRC], WDATA_I[`ARM_STOP_LSB +: 2]) &&
                 WDATA_I[`ARM_DIG_LSB +: 4] >= `DIGITS_MIN;
    wr_gate_ok = gate_ok(WDATA_I[26:0]) && WDATA_I[31:27] == 5'h00;
    wr_func_ok = func_ok(WDATA_I[3:0], new_a, new_b);
    ctl_rst    = WR_I && ADDR_I == `OFF_CONTROL && WDATA_I[`CTL_RST];
    exp_nan_rd = RD_I && (ADDR_I == `OFF_EXP1 || ADDR_I == `OFF_EXP2 ||
                 ADDR_I == `OFF_EXP3) && auto_est[ADDR_I[3:2] - 2'h2];
    bad_wr     = WR_I && ((ADDR_I == `OFF_ARM && !wr_arm_ok) ||
                 (ADDR_I == `OFF_GATE_TIME && !wr_gate_ok) ||
                 (ADDR_I == `OFF_FUNC && !wr_func_ok));
  end

  // Arm settings with reset, recall and checked writes.
  always_ff @(posedge CLK_I) begin
    if (RESET_I || ctl_rst) begin
      start_ext <= 1'b0;
      start_pol <= `RST_START_POL;
      stop_src  <= STOP_TIM;
      stop_pol  <= `RST_STOP_POL;
      digits    <= `RST_DIGITS;
    end else if (WR_I && ADDR_I == `OFF_CONTROL && WDATA_I[`CTL_RECALL]) begin
      start_ext <= saved_arm[`ARM_START_SRC];
      start_pol <= saved_arm[`ARM_START_POL];
      stop_src  <= stop_src_t'(saved_arm[`ARM_STOP_LSB +: 2]);
      stop_pol  <= saved_arm[`ARM_STOP_POL];
      digits    <= saved_arm[`ARM_DIG_LSB +: 4];
    end else if (WR_I && ADDR_I == `OFF_ARM && wr_arm_ok) begin
      start_ext <= WDATA_I[`ARM_START_SRC];
      start_pol <= WDATA_I[`ARM_START_POL];
      stop_src  <= stop_src_t'(WDATA_I[`ARM_STOP_LSB +: 2]);
      stop_pol  <= WDATA_I[`ARM_STOP_POL];
      digits    <= WDATA_I[`ARM_DIG_LSB +: 4];
    end
  end

  // Gate time and function selection.
  always_ff @(posedge CLK_I) begin
    if (RESET_I || ctl_rst) begin
      gate_units <= `RST_GATE_UNITS;
      func       <= FN_FREQ;
      ch_a       <= 2'h1;
      ch_b       <= 2'h0;
    end else if (WR_I && ADDR_I == `OFF_CONTROL && WDATA_I[`CTL_RECALL]) begin
      gate_units <= saved_gate;
      func       <= func_t'(saved_func[3:0]);
      ch_a       <= saved_func[5:4];
      ch_b       <= saved_func[7:6];
    end else if (WR_I && ADDR_I == `OFF_GATE_TIME && wr_gate_ok) begin
      gate_units <= WDATA_I[26:0];
    end else if (WR_I && ADDR_I == `OFF_FUNC && wr_func_ok) begin
      func       <= func_t'(WDATA_I[3:0]);
      ch_a       <= new_a;
      ch_b       <= new_b;
    end
  end

  // Saved instrument state; the frequency hints are deliberately not part of it.
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      saved_arm  <= {20'h00000, `RST_DIGITS, 3'h0, `RST_STOP_POL, 2'h2, `RST_START_POL, 1'b0};
      saved_gate <= `RST_GATE_UNITS;
      saved_func <= 8'h10;
    end else if (WR_I && ADDR_I == `OFF_CONTROL && WDATA_I[`CTL_SAVE]) begin
      saved_arm  <= {20'h00000, digits, 3'h0, stop_pol, stop_src, start_pol, start_ext};
      saved_gate <= gate_units;
      saved_func <= {ch_b, ch_a, func};
    end
  end

  // Expected frequency and auto estimation, per channel.
  always_ff @(posedge CLK_I) begin
    if (RESET_I || ctl_rst) begin
      auto_est <= `RST_AUTO_EST;
      for (int i = 0; i < 3; i++) begin
        exp_freq[i] <= 32'h00000000;
      end
    end else if (WR_I) begin
      for (int i = 0; i < 3; i++) begin
        if (ADDR_I == `OFF_EXP1 + 8'(4 * i) && exp_ok(i, WDATA_I, OPTION_5G_I)) begin
          exp_freq[i] <= WDATA_I;
          auto_est[i] <= 1'b0;
        end
        if (ADDR_I == `OFF_AUTO_EST && WDATA_I[i]) begin
          auto_est[i] <= 1'b1;
        end
      end
    end
  end

  // Error record; a new error wins over the clear done by reading it.
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      err_flag <= 1'b0;
      err_code <= 32'h00000000;
    end else if (exp_nan_rd) begin
      err_flag <= 1'b1;
      err_code <= `ERR_SETTINGS;
    end else if (bad_wr) begin
      err_flag <= 1'b1;
      err_code <= (WR_I && ADDR_I == `OFF_ARM) ? `ERR_SETTINGS : `ERR_RANGE;
    end else if (RD_I && ADDR_I == `OFF_ERROR) begin
      err_flag <= 1'b0;
      err_code <= 32'h00000000;
    end
  end

  // Measurement start pulse and pre-measurement need.
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      arm_pulse  <= 1'b0;
      premeas_en <= 1'b1;
    end else begin
      arm_pulse  <= WR_I && ADDR_I == `OFF_CONTROL && WDATA_I[`CTL_ARM];
      premeas_en <= (func == FN_FREQ || func == FN_PERIOD || func == FN_RATIO ||
                     func == FN_PHASE || func == FN_DUTY) &&
                    (auto_est[ch_a - 2'h1] || (ch_b != 2'h0 && auto_est[ch_b - 2'h1]));
    end
  end

  // Read multiplexer.
  always_comb begin
    case (ADDR_I)
      `OFF_ARM:       next_rdata = {20'h00000, digits, 3'h0, stop_pol, stop_src,
                                    start_pol, start_ext};
      `OFF_GATE_TIME: next_rdata = {5'h00, gate_units};
      `OFF_EXP1, `OFF_EXP2, `OFF_EXP3:
                      next_rdata = auto_est[ADDR_I[3:2] - 2'h2] ? `NAN_CODE :
                                   exp_freq[ADDR_I[3:2] - 2'h2];
      `OFF_AUTO_EST:  next_rdata = {29'h0000000, auto_est};
      `OFF_ERROR:     next_rdata = err_code;
      `OFF_FUNC:      next_rdata = {24'h000000, ch_b, ch_a, func};
      `OFF_CH3_LEVEL: next_rdata = `CH3_LEVEL_VAL;
      `OFF_CH3_SLOPE: next_rdata = `CH3_SLOPE_POS;
      `OFF_STATUS:    next_rdata = {28'h0000000, err_flag, PREMEAS_O, GATE_O, premeas_en};
      `OFF_COUNT_LO:  next_rdata = count[31:0];
      `OFF_COUNT_HI:  next_rdata = 32'(count[CW-1:32]);
      default:        next_rdata = 32'h00000000;
    endcase
  end

  // Read data stand for exactly one cycle after the strobe.
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      RDATA_O <= 32'h00000000;
    end else begin
      RDATA_O <= RD_I ? next_rdata : 32'h00000000;
    end
  end

  gate_sequencer #(
    .CW        (CW),
    .UNIT_CYCS (UNIT_CYCS)
  ) u_seq (
    .CLK_I        (CLK_I),
    .RESET_I      (RESET_I),
    .start_ext_i  (start_ext),
    .start_pol_i  (start_pol),
    .stop_src_i   (stop_src),
    .stop_pol_i   (stop_pol),
    .gate_units_i (gate_units),
    .digits_i     (digits),
    .premeas_en_i (premeas_en),
    .arm_i        (arm_pulse),
    .ext_arm_i    (EXT_ARM_I),
    .event_i      (EVENT_I),
    .gate_open_o  (GATE_O),
    .premeas_o    (PREMEAS_O),
    .done_o       (DONE_O),
    .count_o      (count)
  );

  AST_CH3_LEVEL: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (RD_I && ADDR_I == `OFF_CH3_LEVEL) |=> RDATA_O == 32'h00000000)
    else $error("channel three level not zero");
  AST_CH3_SLOPE: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (RD_I && ADDR_I == `OFF_CH3_SLOPE) |=> RDATA_O == 32'h00000001)
    else $error("channel three slope not positive");
  AST_BAD_PAIR: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (WR_I && ADDR_I == `OFF_ARM && WDATA_I[0] && WDATA_I[3:2] == 2'h3)
      |=> ($stable(stop_src) && $stable(start_ext) && err_flag))
    else $error("forbidden pairing accepted");
  AST_NAN_READ: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (RD_I && ADDR_I == `OFF_EXP1 && auto_est[0])
      |=> (RDATA_O == `NAN_CODE && err_flag && err_code == 32'hffffff23))
    else $error("expected frequency read under auto not refused");
  AST_AUTO_ON: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (WR_I && ADDR_I == `OFF_AUTO_EST && WDATA_I[2] && !ctl_rst) |=> auto_est[2])
    else $error("auto estimation did not turn on");
  AST_RECALL_KEEP: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (WR_I && ADDR_I == `OFF_CONTROL && WDATA_I[3:1] == 3'h4)
      |=> ($stable(auto_est) && exp_freq[1] == $past(exp_freq[1])))
    else $error("recall touched frequency hints");
  AST_RATIO: assert property (@(posedge CLK_I) disable iff (RESET_I)
    func == FN_RATIO |-> ((ch_a == 2'h1 && ch_b[1]) || (ch_b == 2'h1 && ch_a[1])))
    else $error("illegal ratio channel pair");

endmodule
`default_nettype wire

// ---- rtl/gate_arm_params.svh ----
`ifndef GATE_ARM_PARAMS_SVH
`define GATE_ARM_PARAMS_SVH

// Register byte offsets.
`define OFF_ARM        8'h00
`define OFF_GATE_TIME  8'h04
`define OFF_EXP1       8'h08
`define OFF_EXP2       8'h0c
`define OFF_EXP3       8'h10
`define OFF_AUTO_EST   8'h14
`define OFF_ERROR      8'h18
`define OFF_FUNC       8'h1c
`define OFF_CH3_LEVEL  8'h20
`define OFF_CH3_SLOPE  8'h24
`define OFF_STATUS     8'h28
`define OFF_COUNT_LO   8'h2c
`define OFF_COUNT_HI   8'h30
`define OFF_CONTROL    8'h34

// Arm register field positions.
`define ARM_START_SRC  0
`define ARM_START_POL  1
`define ARM_STOP_LSB   2
`define ARM_STOP_POL   4
`define ARM_DIG_LSB    8

// Control register bits.
`define CTL_ARM        0
`define CTL_RST        1
`define CTL_SAVE       2
`define CTL_RECALL     3

// Reset values.
`define RST_START_POL  1'b1
`define RST_STOP_POL   1'b0
`define RST_DIGITS     4'h4
`define RST_GATE_UNITS 27'h0002710
`define RST_AUTO_EST   3'h7

// Limits; gate time counts 10 us units, channel 1/2 in 0.1 Hz, channel 3 in kHz.
`define DIGITS_MIN     4'h3
`define DIGITS_MAX     4'hf
`define GATE_SHORT_MIN 27'h0000064
`define GATE_SHORT_MAX 27'h000270f
`define GATE_LONG_MIN  27'h0002710
`define GATE_LONG_MAX  27'h5f5e100
`define GATE_LONG_STEP 27'h0000064
`define EXP12_MIN      32'h00000001
`define EXP12_MAX      32'h861c4680
`define EXP3A_MIN      32'h000186a0
`define EXP3A_MAX      32'h002dc6c0
`define EXP3B_MIN      32'h00030d40
`define EXP3B_MAX      32'h004c4b40

// Answers and error codes.
`define NAN_CODE       32'h7fc00000
`define ERR_SETTINGS   32'hffffff23
`define ERR_RANGE      32'hffffff22
`define CH3_LEVEL_VAL  32'h00000000
`define CH3_SLOPE_POS  32'h00000001

// Timing.
`define CLK_PERIOD_NS  5
`define GATE_UNIT_NS   10000
`define GATE_UNIT_CYC  ((`GATE_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PREMEAS_UNITS  27'h0000064

`endif

// ---- rtl/gate_pkg.sv ----
package gate_pkg;

  typedef enum logic [1:0] {
    STOP_IMM = 2'h0,
    STOP_EXT = 2'h1,
    STOP_TIM = 2'h2,
    STOP_DIG = 2'h3
  } stop_src_t;

  typedef enum logic [3:0] {
    FN_FREQ   = 4'h0,
    FN_PERIOD = 4'h1,
    FN_RATIO  = 4'h2,
    FN_PHASE  = 4'h3,
    FN_DUTY   = 4'h4,
    FN_INTVL  = 4'h5,
    FN_PWID   = 4'h6,
    FN_NWID   = 4'h7,
    FN_RISE   = 4'h8,
    FN_FALL   = 4'h9,
    FN_TOTAL  = 4'ha,
    FN_VMAX   = 4'hb,
    FN_VMIN   = 4'hc,
    FN_PTP    = 4'hd
  } func_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_PRE  = 4'b0010,
    S_WAIT = 4'b0100,
    S_OPEN = 4'b1000
  } gate_state_t;

endpackage

// ---- rtl/gate_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "gate_arm_params.svh"
module gate_sequencer #(
  parameter int CW        = 50,
  parameter int UNIT_CYCS = `GATE_UNIT_CYC
) (
  // Clock and reset.
  input  wire logic                CLK_I,
  input  wire logic                RESET_I,
  // Settings.
  input  wire logic                start_ext_i,
  input  wire logic                start_pol_i,
  input  wire gate_pkg::stop_src_t stop_src_i,
  input  wire logic                stop_pol_i,
  input  wire logic [26:0]         gate_units_i,
  input  wire logic [3:0]          digits_i,
  input  wire logic                premeas_en_i,
  // Requests and pins.
  input  wire logic                arm_i,
  input  wire logic                ext_arm_i,
  input  wire logic                event_i,
  // Results.
  output logic                     gate_open_o,
  output logic                     premeas_o,
  output logic                     done_o,
  output logic [CW-1:0]            count_o
);
  import gate_pkg::*;

  gate_state_t state;
  logic [15:0] presc;
  logic [26:0] units;
  logic        start_edge;
  logic        stop_edge;
  logic        ev_edge;
  logic        close_now;

  // Power of ten as an event target for the digits stop.
  function automatic logic [CW-1:0] pow10(input logic [3:0] d);
    logic [CW-1:0] v;
    v = {{(CW-1){1'b0}}, 1'b1};
    for (int i = 1; i < 16; i++) begin
      if (i < d) begin
        v = CW'(v * 10);
      end
    end
    return v;
  endfunction

  edge_pick u_start (.CLK_I(CLK_I), .RESET_I(RESET_I), .sig_i(ext_arm_i),
                     .rising_i(start_pol_i), .pulse_o(start_edge));
  edge_pick u_stop (.CLK_I(CLK_I), .RESET_I(RESET_I), .sig_i(ext_arm_i),
                    .rising_i(stop_pol_i), .pulse_o(stop_edge));
  edge_pick u_event (.CLK_I(CLK_I), .RESET_I(RESET_I), .sig_i(event_i),
                     .rising_i(1'b1), .pulse_o(ev_edge));

  // Close condition of the open gate for each stop source.
  always_comb begin
    case (stop_src_i)
      STOP_IMM: close_now = ev_edge;
      STOP_EXT: close_now = stop_edge;
      STOP_TIM: close_now = (units == gate_units_i);
      STOP_DIG: close_now = (count_o == pow10(digits_i));
      default:  close_now = 1'b1;
    endcase
  end

  // Gate state sequence.
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      state <= S_IDLE;
    end else begin
      case (state)
        S_IDLE: if (arm_i) state <= premeas_en_i ? S_PRE : S_WAIT;
        S_PRE:  if (units == `PREMEAS_UNITS) state <= S_WAIT;
        S_WAIT: if (!start_ext_i || start_edge) state <= S_OPEN;
        S_OPEN: if (close_now) state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  // Prescaler and 10 us unit counter, cleared on entry to timed states.
  always_ff @(posedge CLK_I) begin
    if (RESET_I || state == S_IDLE || state == S_WAIT) begin
      presc <= 16'h0000;
      units <= 27'h0000000;
    end else if (presc == 16'(UNIT_CYCS - 1)) begin
      presc <= 16'h0000;
      units <= units + 27'h0000001;
    end else begin
      presc <= presc + 16'h0001;
    end
  end

  // Event counter runs only while the gate is open.
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      count_o <= '0;
    end else if (state == S_WAIT && (!start_ext_i || start_edge)) begin
      count_o <= '0;
    end else if (state == S_OPEN && ev_edge) begin
      count_o <= count_o + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // Registered status outputs.
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      gate_open_o <= 1'b0;
      premeas_o   <= 1'b0;
      done_o      <= 1'b0;
    end else begin
      gate_open_o <= (state == S_WAIT && (!start_ext_i || start_edge)) ||
                     (state == S_OPEN && !close_now);
      premeas_o   <= (state == S_IDLE && arm_i && premeas_en_i) ||
                     (state == S_PRE && units != `PREMEAS_UNITS);
      done_o      <= (state == S_OPEN && close_now);
    end
  end

  AST_COUNT_IN_GATE: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (count_o != $past(count_o) && $past(state) != S_WAIT) |-> $past(state == S_OPEN))
    else $error("count moved while gate closed");
  AST_TIMER_CLOSE: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (state == S_OPEN && stop_src_i == STOP_TIM && units == gate_units_i)
      |=> (done_o && !gate_open_o && state == S_IDLE))
    else $error("timer gate did not close");
  AST_EXT_START: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (state == S_WAIT && start_ext_i && !start_edge) |=> !gate_open_o)
    else $error("gate opened without external start edge");
  AST_EXT_STOP: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (state == S_OPEN && stop_src_i == STOP_EXT && !stop_edge) |=> state == S_OPEN)
    else $error("external stop closed without its edge");
  AST_DIGITS: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (state == S_OPEN && stop_src_i == STOP_DIG && count_o == pow10(digits_i))
      |=> done_o)
    else $error("digits gate did not close at target");
  AST_PREMEAS: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (state == S_IDLE && arm_i) |=> (premeas_o == $past(premeas_en_i)))
    else $error("pre-measurement step wrong");

endmodule
`default_nettype wire
